// >>> logic/msac_top.sv
// Sweep acquisition control: time and sweep counters, presets, sync outputs.
// Assumes all inputs synchronous to clk and an APB master on the register bus.
//
// Behaviour
// - Wrap-around: time counter keeps running, sweeps never end on range.
// - Sweep mode: each sweep waits for a start pulse.
// - Software start: sweeps begin without an external start.
// - Bin value masked to the spectrum range; higher bits dropped.
// - Sync sources: idle, begin, end, overflows, time counter bit 0..26.
// - Sync can also follow any sweep counter bit 0..31.
// - Time counter steps every 32 dwell ticks, 16 in reduced speed.
// - Start event generation puts a zero word into the stream.
// - Sweep preset stops measurement when sweep count reaches preset.
// - Single sweeps: halt at preset, drain both stages, then resume.
// - DMA mode flag goes to the data path; otherwise port reads.
// - Time preset stops measurement after programmed duration.
// - Bin width is a power of two of the dwell time, up to 16384.
// - No events accepted before the acquisition delay elapses.
// - Sequential cycles: own region each, stop after programmed count.
// - Programmed range in bins ends each sweep's window.
// - Acquisition delay programmed in steps of 16 time counter counts from the start.
// - 32-bit sweep counter counts starts; blocks starts at preset.
`timescale 1ns/10ps
`include "msac_map.svh"

module msac_top
	import msac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        dwell_tick,
	input  wire logic        start_pulse,
	input  wire logic        stop_event,
	input  wire logic        first_stage_overflow,
	input  wire logic        second_stage_overflow,
	input  wire logic        first_stage_empty,
	input  wire logic        second_stage_empty,
	output logic             event_valid,
	output logic      [31:0] event_data,
	output logic             dma_enable,
	output logic             acq_running,
	output logic      [15:0] mem_region,
	output logic             sync_out0,
	output logic             sync_out1
);

	// ==========================================================
	// Helpers
	// Smear range-1 downward so every bit below its top bit is kept
	function automatic logic [31:0] range_mask(input logic [31:0] r);
		logic [31:0] m;
		m = r - 32'h00000001;
		for (int i = 0; i < 5; i++) begin
			m = m | (m >> (1 << i));
		end
		return m;
	endfunction

	function automatic logic sync_pick(input logic [12:0] sel, input logic idle,
		input logic first, input logic last, input logic [31:0] tc,
		input logic [31:0] sc);
		logic r;
		r = 1'b0;
		case (sel[2:0])
			`MSAC_SRC_IDLE:  r = idle;
			`MSAC_SRC_FIRST: r = first;
			`MSAC_SRC_LAST:  r = last;
			`MSAC_SRC_FF1:   r = first_stage_overflow;
			`MSAC_SRC_FF2:   r = second_stage_overflow;
			`MSAC_SRC_COUNT: r = (sel[12:8] <= `MSAC_COUNT_BIT_MAX) ? tc[sel[12:8]] : 1'b0;
			`MSAC_SRC_SWEEP: r = sc[sel[12:8]];
			default:         r = 1'b0;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Register file state
	logic [9:0]  ctrl_reg, ctrl_next;
	logic [31:0] range_reg, range_next;
	logic [3:0]  binw_reg, binw_next;
	logic [31:0] delay_reg, delay_next;
	logic [31:0] swp_pre_reg, swp_pre_next;
	logic [31:0] time_pre_reg, time_pre_next;
	logic [15:0] cyc_pre_reg, cyc_pre_next;
	logic [12:0] sync0_reg, sync0_next;
	logic [12:0] sync1_reg, sync1_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] rd_word;
	logic        rd_hit;

	// ==========================================================
	// Sequencer state
	msac_state_t state_reg, state_next;
	logic [4:0]  pre_reg, pre_next;
	logic [31:0] tc_reg, tc_next;
	logic [31:0] sc_reg, sc_next;
	logic        acq_reg, acq_next;
	logic [5:0]  tpc_reg, tpc_next;
	logic [31:0] tp_reg, tp_next;
	logic [15:0] cyc_reg, cyc_next;
	logic        ev_v_reg, ev_v_next;
	logic [31:0] ev_d_reg, ev_d_next;
	logic        first_reg, first_next;
	logic        last_reg, last_next;
	logic [1:0]  sync_reg, sync_next;
	logic        fin;

	logic        wr_en;
	logic        host_stop;
	logic [4:0]  div_last;
	logic        step;
	logic [35:0] dly16;
	logic        acq_now;
	logic [31:0] bin;
	logic        in_range;
	logic        swp_hit;
	logic        time_hit;
	logic        start_ok;
	logic        drained;

	// ==========================================================
	// Decode and datapath terms
	assign wr_en     = psel && penable && pwrite;
	assign host_stop = wr_en && (paddr == `MSAC_OFS_CMD) && pwdata[`MSAC_CMD_STOP];
	assign div_last  = ctrl_reg[`MSAC_CTRL_REDUCED] ? 5'(`MSAC_DWELL_DIV_RED - 1)
	                                                : 5'(`MSAC_DWELL_DIV - 1);
	assign step      = dwell_tick && (pre_reg == div_last);
	assign dly16     = {delay_reg, 4'h0};
	assign acq_now   = {4'h0, tc_reg} >= dly16;
	assign bin       = (tc_reg - dly16[31:0]) >> binw_reg;
	assign in_range  = bin < range_reg;
	assign swp_hit   = ctrl_reg[`MSAC_CTRL_SWP_EN] && (sc_reg >= swp_pre_reg);
	assign time_hit  = ctrl_reg[`MSAC_CTRL_TP_EN] && (tp_reg >= time_pre_reg);
	assign start_ok  = start_pulse || ctrl_reg[`MSAC_CTRL_SOFT];
	assign drained   = first_stage_empty && second_stage_empty;

	// ==========================================================
	// APB register file, next values
	always_comb begin
		ctrl_next     = ctrl_reg;
		range_next    = range_reg;
		binw_next     = binw_reg;
		delay_next    = delay_reg;
		swp_pre_next  = swp_pre_reg;
		time_pre_next = time_pre_reg;
		cyc_pre_next  = cyc_pre_reg;
		sync0_next    = sync0_reg;
		sync1_next    = sync1_reg;
		prdata_next   = prdata_reg;
		pslverr_next  = pslverr_reg;
		rd_hit        = 1'b1;
		rd_word       = 32'h00000000;
		case (paddr)
			`MSAC_OFS_CTRL:     rd_word = {22'h000000, ctrl_reg};
			`MSAC_OFS_STATUS:   rd_word = {26'h0000000, (state_reg == ST_DONE),
				time_hit, swp_hit, (state_reg == ST_DRAIN), (state_reg == ST_SWEEP),
				acq_running};
			`MSAC_OFS_RANGE:    rd_word = range_reg;
			`MSAC_OFS_BINW:     rd_word = {28'h0000000, binw_reg};
			`MSAC_OFS_DELAY:    rd_word = delay_reg;
			`MSAC_OFS_SWP_PRE:  rd_word = swp_pre_reg;
			`MSAC_OFS_TIME_PRE: rd_word = time_pre_reg;
			`MSAC_OFS_CYC_PRE:  rd_word = {16'h0000, cyc_pre_reg};
			`MSAC_OFS_SYNC0:    rd_word = {19'h00000, sync0_reg};
			`MSAC_OFS_SYNC1:    rd_word = {19'h00000, sync1_reg};
			`MSAC_OFS_SWP_CNT:  rd_word = sc_reg;
			`MSAC_OFS_TIME_CNT: rd_word = tc_reg;
			`MSAC_OFS_CYC_CNT:  rd_word = {16'h0000, cyc_reg};
			`MSAC_OFS_CMD:      rd_word = 32'h00000000;
			default:            rd_hit = 1'b0;
		endcase
		// Answer is captured in setup so the access phase never waits
		if (psel && !penable) begin
			prdata_next  = pwrite ? 32'h00000000 : rd_word;
			pslverr_next = !rd_hit;
		end
		if (wr_en) begin
			case (paddr)
				`MSAC_OFS_CTRL:     ctrl_next = pwdata[9:0];
				`MSAC_OFS_RANGE:    range_next = pwdata;
				// Widths above the largest power are clipped, not wrapped
				`MSAC_OFS_BINW:     binw_next = (pwdata[3:0] > `MSAC_BINW_MAX) ?
					`MSAC_BINW_MAX : pwdata[3:0];
				`MSAC_OFS_DELAY:    delay_next = pwdata;
				`MSAC_OFS_SWP_PRE:  swp_pre_next = pwdata;
				`MSAC_OFS_TIME_PRE: time_pre_next = pwdata;
				`MSAC_OFS_CYC_PRE:  cyc_pre_next = pwdata[15:0];
				`MSAC_OFS_SYNC0:    sync0_next = pwdata[12:0];
				`MSAC_OFS_SYNC1:    sync1_next = pwdata[12:0];
				default:            ctrl_next = ctrl_reg;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg     <= 10'h000;
			range_reg    <= `MSAC_RST_RANGE;
			binw_reg     <= 4'h0;
			delay_reg    <= 32'h00000000;
			swp_pre_reg  <= `MSAC_RST_PRESET;
			time_pre_reg <= `MSAC_RST_PRESET;
			cyc_pre_reg  <= `MSAC_RST_CYC;
			sync0_reg    <= 13'h0000;
			sync1_reg    <= 13'h0000;
			prdata_reg   <= 32'h00000000;
			pslverr_reg  <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			range_reg    <= range_next;
			binw_reg     <= binw_next;
			delay_reg    <= delay_next;
			swp_pre_reg  <= swp_pre_next;
			time_pre_reg <= time_pre_next;
			cyc_pre_reg  <= cyc_pre_next;
			sync0_reg    <= sync0_next;
			sync1_reg    <= sync1_next;
			prdata_reg   <= prdata_next;
			pslverr_reg  <= pslverr_next;
		end
	end

	// ==========================================================
	// Sweep sequencer, next values
	always_comb begin
		state_next = state_reg;
		pre_next   = pre_reg;
		tc_next    = tc_reg;
		sc_next    = sc_reg;
		acq_next   = acq_reg;
		tpc_next   = tpc_reg;
		tp_next    = tp_reg;
		cyc_next   = cyc_reg;
		ev_v_next  = 1'b0;
		ev_d_next  = ev_d_reg;
		first_next = 1'b0;
		last_next  = 1'b0;
		fin        = 1'b0;
		// Elapsed time counts while a measurement is live
		if (acq_running) begin
			tpc_next = (tpc_reg == 6'(`MSAC_PRESET_CYC - 1)) ? 6'h00 : tpc_reg + 6'h01;
			if (tpc_reg == 6'(`MSAC_PRESET_CYC - 1))
				tp_next = tp_reg + 32'h00000001;
		end
		case (state_reg)
			ST_IDLE: begin
				if (ctrl_reg[`MSAC_CTRL_RUN]) begin
					sc_next    = 32'h00000000;
					tp_next    = 32'h00000000;
					tpc_next   = 6'h00;
					cyc_next   = 16'h0000;
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (time_hit || host_stop || (swp_hit && !ctrl_reg[`MSAC_CTRL_SINGLE])) begin
					fin = 1'b1;
				end else if (swp_hit) begin
					state_next = ST_DRAIN;
				end else if (start_ok) begin
					sc_next    = sc_reg + 32'h00000001;
					tc_next    = 32'h00000000;
					pre_next   = 5'h00;
					acq_next   = 1'b0;
					state_next = ST_SWEEP;
					if (ctrl_reg[`MSAC_CTRL_STEV]) begin
						ev_v_next = 1'b1;
						ev_d_next = 32'h00000000;
					end
				end
			end
			ST_SWEEP: begin
				if (dwell_tick)
					pre_next = step ? 5'h00 : pre_reg + 5'h01;
				if (step)
					tc_next = tc_reg + 32'h00000001;
				if (acq_now && !acq_reg) begin
					acq_next   = 1'b1;
					first_next = 1'b1;
				end
				// Event words are bin+1 so zero stays unique to starts
				if (stop_event && acq_reg && (ctrl_reg[`MSAC_CTRL_WRAP] || in_range)) begin
					ev_v_next = 1'b1;
					ev_d_next = (bin & range_mask(range_reg)) + 32'h00000001;
				end
				if (time_hit || host_stop) begin
					fin       = 1'b1;
					last_next = 1'b1;
				end else if (!ctrl_reg[`MSAC_CTRL_WRAP] && acq_reg && !in_range) begin
					last_next  = 1'b1;
					state_next = ST_WAIT;
				end
			end
			ST_DRAIN: begin
				if (time_hit || host_stop) begin
					fin = 1'b1;
				end else if (drained) begin
					sc_next    = 32'h00000000;
					state_next = ST_WAIT;
				end
			end
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		// Cycle end: next region or whole run finished
		if (fin) begin
			if (ctrl_reg[`MSAC_CTRL_SEQ] && ((cyc_reg + 16'h0001) < cyc_pre_reg)) begin
				cyc_next   = cyc_reg + 16'h0001;
				sc_next    = 32'h00000000;
				tp_next    = 32'h00000000;
				tpc_next   = 6'h00;
				state_next = ST_WAIT;
			end else begin
				state_next = ST_DONE;
			end
		end
		// Clearing run aborts any phase
		if (!ctrl_reg[`MSAC_CTRL_RUN])
			state_next = ST_IDLE;
		sync_next[0] = sync_pick(sync0_reg, state_next != ST_SWEEP, first_next, last_next,
			tc_next, sc_next);
		sync_next[1] = sync_pick(sync1_reg, state_next != ST_SWEEP, first_next, last_next,
			tc_next, sc_next);
	end

	// Sequencer flops
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			pre_reg   <= 5'h00;
			tc_reg    <= 32'h00000000;
			sc_reg    <= 32'h00000000;
			acq_reg   <= 1'b0;
			tpc_reg   <= 6'h00;
			tp_reg    <= 32'h00000000;
			cyc_reg   <= 16'h0000;
			ev_v_reg  <= 1'b0;
			ev_d_reg  <= 32'h00000000;
			first_reg <= 1'b0;
			last_reg  <= 1'b0;
			sync_reg  <= 2'h3;
		end else begin
			state_reg <= state_next;
			pre_reg   <= pre_next;
			tc_reg    <= tc_next;
			sc_reg    <= sc_next;
			acq_reg   <= acq_next;
			tpc_reg   <= tpc_next;
			tp_reg    <= tp_next;
			cyc_reg   <= cyc_next;
			ev_v_reg  <= ev_v_next;
			ev_d_reg  <= ev_d_next;
			first_reg <= first_next;
			last_reg  <= last_next;
			sync_reg  <= sync_next;
		end
	end

	// ==========================================================
	// Outputs
	assign pready      = 1'b1;
	assign prdata      = prdata_reg;
	assign pslverr     = pslverr_reg;
	assign event_valid = ev_v_reg;
	assign event_data  = ev_d_reg;
	assign dma_enable  = ctrl_reg[`MSAC_CTRL_DMA];
	assign acq_running = (state_reg == ST_WAIT) || (state_reg == ST_SWEEP) ||
	                     (state_reg == ST_DRAIN);
	assign mem_region  = cyc_reg;
	assign sync_out0   = sync_reg[0];
	assign sync_out1   = sync_reg[1];

endmodule // msac_top

// >>> logic/msac_map.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`ifndef MSAC_MAP_SVH
`define MSAC_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define MSAC_OFS_CTRL      8'h00
`define MSAC_OFS_STATUS    8'h04
`define MSAC_OFS_RANGE     8'h08
`define MSAC_OFS_BINW      8'h0C
`define MSAC_OFS_DELAY     8'h10
`define MSAC_OFS_SWP_PRE   8'h14
`define MSAC_OFS_TIME_PRE  8'h18
`define MSAC_OFS_CYC_PRE   8'h1C
`define MSAC_OFS_SYNC0     8'h20
`define MSAC_OFS_SYNC1     8'h24
`define MSAC_OFS_SWP_CNT   8'h28
`define MSAC_OFS_TIME_CNT  8'h2C
`define MSAC_OFS_CYC_CNT   8'h30
`define MSAC_OFS_CMD       8'h34
// ==========================================================
// Control fields
`define MSAC_CTRL_RUN      0
`define MSAC_CTRL_WRAP     1
`define MSAC_CTRL_SOFT     2
`define MSAC_CTRL_STEV     3
`define MSAC_CTRL_SWP_EN   4
`define MSAC_CTRL_SINGLE   5
`define MSAC_CTRL_DMA      6
`define MSAC_CTRL_SEQ      7
`define MSAC_CTRL_TP_EN    8
`define MSAC_CTRL_REDUCED  9
`define MSAC_CMD_STOP      0
// ==========================================================
// Sync selector: source code in [2:0], bit index in [12:8]
`define MSAC_SRC_IDLE      3'h0
`define MSAC_SRC_FIRST     3'h1
`define MSAC_SRC_LAST      3'h2
`define MSAC_SRC_FF1       3'h3
`define MSAC_SRC_FF2       3'h4
`define MSAC_SRC_COUNT     3'h5
`define MSAC_SRC_SWEEP     3'h6
`define MSAC_COUNT_BIT_MAX 5'h1A
// ==========================================================
// Reset values
`define MSAC_RST_RANGE     32'h00001000
`define MSAC_RST_PRESET    32'h00000001
`define MSAC_RST_CYC       16'h0001
// ==========================================================
// Timing
`define MSAC_CLK_NS        25
`define MSAC_PRESET_UNIT_NS 1000
`define MSAC_PRESET_CYC    (`MSAC_PRESET_UNIT_NS / `MSAC_CLK_NS)
`define MSAC_DWELL_DIV     32
`define MSAC_DWELL_DIV_RED 16
`define MSAC_BINW_MAX      4'hE
`endif

// >>> logic/msac_pkg.sv
// Types shared by the sweep acquisition control.
// Assumes the map header is compiled alongside.
package msac_pkg;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SWEEP,
		ST_DRAIN,
		ST_DONE
	} msac_state_t;
endpackage

// >>> bench/msac_chk_sva.sv
// Port checker for the sweep acquisition control.
// Assumes it is bound to msac_top and sees only its ports.
`timescale 1ns/10ps
`include "msac_map.svh"
module msac_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        first_stage_overflow,
	input wire logic        event_valid,
	input wire logic [31:0] event_data,
	input wire logic        dma_enable,
	input wire logic        acq_running,
	input wire logic [15:0] mem_region,
	input wire logic        sync_out0
);
	// ==========================================================
	// Register mirrors
	logic        wr;
	logic [9:0]  ctrl_m;
	logic [12:0] sel0_m;
	logic [31:0] range_m;
	assign wr = psel && penable && pwrite && pready;
	// Own shadow copies, so a broken read path cannot hide a fault
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_m  <= 10'h000;
			sel0_m  <= 13'h0000;
			range_m <= `MSAC_RST_RANGE;
		end else if (wr) begin
			if (paddr == `MSAC_OFS_CTRL) ctrl_m <= pwdata[9:0];
			if (paddr == `MSAC_OFS_SYNC0) sel0_m <= pwdata[12:0];
			if (paddr == `MSAC_OFS_RANGE) range_m <= pwdata;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_reset_idle;
		$rose(reset_n) |-> !acq_running && mem_region == 16'h0000;
	endproperty
	property p_dma;
		wr && paddr == `MSAC_OFS_CTRL |=> dma_enable == ctrl_m[`MSAC_CTRL_DMA];
	endproperty
	property p_ovf_sync;
		sel0_m[2:0] == `MSAC_SRC_FF1 && $stable(sel0_m)
			|=> sync_out0 == $past(first_stage_overflow);
	endproperty
	property p_idle_sync;
		sel0_m[2:0] == `MSAC_SRC_IDLE && $stable(sel0_m) && !acq_running |=> sync_out0;
	endproperty
	property p_no_evt_idle;
		!acq_running && !$past(acq_running) |-> !event_valid;
	endproperty
	property p_region;
		$changed(mem_region)
			|-> mem_region == $past(mem_region) + 16'h0001 || mem_region == 16'h0000;
	endproperty
	property p_range;
		event_valid && event_data != 32'h0 |-> event_data <= range_m;
	endproperty
	// Software start with start words: a zero word soon after run is set
	property p_soft;
		wr && paddr == `MSAC_OFS_CTRL && pwdata[3:2] == 2'h3 && pwdata[0] && !ctrl_m[0]
			|-> ##[2:6] event_valid && event_data == 32'h0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
	a_dma: assert property (p_dma) else $error("dma flag wrong");
	a_ovf_sync: assert property (p_ovf_sync) else $error("overflow sync wrong");
	a_idle_sync: assert property (p_idle_sync) else $error("idle sync low");
	a_no_evt_idle: assert property (p_no_evt_idle) else $error("word while idle");
	a_region: assert property (p_region) else $error("region jumped");
	a_range: assert property (p_range) else $error("word beyond range");
	a_soft: assert property (p_soft) else $error("no soft start word");
	c_start: cover property (event_valid && event_data == 32'h0);
	c_stop: cover property (event_valid && event_data != 32'h0);
	c_region: cover property ($changed(mem_region));
endmodule // msac_chk

bind msac_top msac_chk u_chk (
	.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready),
	.first_stage_overflow(first_stage_overflow), .event_valid(event_valid),
	.event_data(event_data), .dma_enable(dma_enable), .acq_running(acq_running),
	.mem_region(mem_region), .sync_out0(sync_out0)
);

// >>> bench/msac_stage_model.sv
// Stand-in for the two buffer stages and the host draining them.
// Assumes one clock; stall comes from the bench to make the host slow.
`timescale 1ns/10ps
module msac_stage_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic stop_event,
	input  wire logic event_valid,
	input  wire logic stall,
	output logic      first_stage_overflow,
	output logic      second_stage_overflow,
	output logic      first_stage_empty,
	output logic      second_stage_empty
);
	// ==========================================================
	// Occupancy
	int n1;
	int n2;
	// Small depths so a stalled host really fills up
	always @(posedge clk) begin
		if (!reset_n) begin
			n1 <= 0;
			n2 <= 0;
		end else begin
			n1 <= n1 + stop_event - (!stall && n1 > 0);
			n2 <= n2 + event_valid + (!stall && n1 > 0) - (!stall && n2 > 0);
		end
	end
	assign first_stage_overflow  = (n1 >= 2);
	assign second_stage_overflow = (n2 >= 4);
	assign first_stage_empty     = (n1 == 0);
	assign second_stage_empty    = (n2 == 0);
endmodule // msac_stage_model

// >>> bench/msac_top_test.sv
// Self-checking bench for the sweep acquisition control.
// Assumes the stage model on the data path and an APB master here.
`timescale 1ns/10ps
`include "msac_map.svh"
module msac_top_test;
	// ==========================================================
	// Signals
	logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdat, lfsr = 32'h3527;
	logic        dwell_tick = 1, start_pulse = 0, stop_event = 0, stall = 0, rerr, o;
	logic        pready, pslverr, ovf1, ovf2, emp1, emp2, event_valid, dma_enable;
	logic        acq_running, sync_out0, sync_out1;
	logic [31:0] prdata, event_data;
	logic [15:0] mem_region;
	logic [31:0] got[$], exp[$];
	int          bad_count = 0, n_compared = 0;
	logic [7:0]  ra[5] = '{`MSAC_OFS_CTRL, `MSAC_OFS_RANGE, `MSAC_OFS_SWP_PRE,
		`MSAC_OFS_TIME_PRE, `MSAC_OFS_SWP_CNT};
	logic [31:0] rv[5] = '{32'h0, `MSAC_RST_RANGE, `MSAC_RST_PRESET, `MSAC_RST_PRESET, 32'h0};

	msac_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .dwell_tick(dwell_tick), .start_pulse(start_pulse),
		.stop_event(stop_event), .first_stage_overflow(ovf1), .second_stage_overflow(ovf2),
		.first_stage_empty(emp1), .second_stage_empty(emp2), .event_valid(event_valid),
		.event_data(event_data), .dma_enable(dma_enable), .acq_running(acq_running),
		.mem_region(mem_region), .sync_out0(sync_out0), .sync_out1(sync_out1));
	msac_stage_model u_stage (.clk(clk), .reset_n(reset_n), .stop_event(stop_event),
		.event_valid(event_valid), .stall(stall), .first_stage_overflow(ovf1),
		.second_stage_overflow(ovf2), .first_stage_empty(emp1), .second_stage_empty(emp2));

	// ==========================================================
	// Clock, random host stalls, stream monitor
	always #12.5 clk = ~clk;
	// Next state of the random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge clk) begin
		lfsr <= lfsr_next(lfsr);
		stall <= lfsr[0];
		if (event_valid === 1'b1) got.push_back(event_data);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; the extra edge keeps back-to-back calls clean
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic start;
		start_pulse <= 1'b1;
		tick(1);
		start_pulse <= 1'b0;
	endtask
	task automatic stop;
		stop_event <= 1'b1;
		tick(1);
		stop_event <= 1'b0;
	endtask
	// Stream words against the model queue, then both emptied
	task automatic cmp_q;
		check(got.size(), exp.size());
		while (got.size() > 0 && exp.size() > 0) check(got.pop_front(), exp.pop_front());
		got.delete();
		exp.delete();
	endtask
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: whole run is under two thousand cycles
	initial begin
		#(25 * 20000);
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		summarize();
	end

	// ==========================================================
	// Scenarios
	initial begin
		tick(6);
		reset_n <= 1'b1;
		tick(3);
		check({sync_out0, sync_out1}, 32'h3);
		for (int i = 0; i < 5; i++) begin
			apb(0, ra[i], 32'h0);
			check(rdat, rv[i]);
		end
		apb(0, 8'h40, 32'h0);
		check(rerr, 1'b1);
		check(rdat, 32'h0);
		apb(1, `MSAC_OFS_CTRL, 32'h40);
		check(dma_enable, 32'h1);
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		check(dma_enable, 32'h0);
		// Sweep mode, preset of two sweeps; third start must be refused
		apb(1, `MSAC_OFS_RANGE, 32'h2);
		apb(1, `MSAC_OFS_SWP_PRE, 32'h2);
		apb(1, `MSAC_OFS_CTRL, 32'h19);
		for (int i = 0; i < 3; i++) begin
			start();
			tick(5);
			if (i < 2) exp.push_back(32'h0);
			stop();
			if (i < 2) exp.push_back(32'h1);
			tick(120);
		end
		cmp_q();
		check(acq_running, 32'h0);
		apb(0, `MSAC_OFS_SWP_CNT, 32'h0);
		check(rdat, 32'h2);
		for (int j = 0; j < 2; j++) begin
			apb(1, `MSAC_OFS_SYNC1, 32'h006 | (j << 8));
			tick(2);
			check(sync_out1, j);
		end
		// Wrap with software start and a delay: early stop dropped, sweep never ends
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_DELAY, 32'h1);
		apb(1, `MSAC_OFS_CTRL, 32'hF);
		exp.push_back(32'h0);
		tick(10);
		stop();
		tick(200);
		apb(0, `MSAC_OFS_STATUS, 32'h0);
		check(rdat[1], 32'h1);
		cmp_q();
		// Time counter step in both speeds
		for (int m = 0; m < 2; m++) begin
			apb(1, `MSAC_OFS_CTRL, 32'h0);
			apb(1, `MSAC_OFS_CTRL, 32'h7 | (m << 9));
			tick((m ? 16 : 32) * 5 + (m ? 8 : 16) - 4);
			apb(0, `MSAC_OFS_TIME_CNT, 32'h0);
			check(rdat, 32'h5);
			// No dwell ticks: the time counter must hold
			dwell_tick <= 1'b0;
			tick(40);
			apb(0, `MSAC_OFS_TIME_CNT, 32'h0);
			check(rdat, 32'h5);
			dwell_tick <= 1'b1;
		end
		// Time preset of 2 units
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_TIME_PRE, 32'h2);
		apb(1, `MSAC_OFS_CTRL, 32'h107);
		tick(50);
		check(acq_running, 32'h1);
		tick(50);
		check(acq_running, 32'h0);
		// Sequential cycles ended by the host stop command
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_CYC_PRE, 32'h2);
		apb(1, `MSAC_OFS_CTRL, 32'h87);
		apb(1, `MSAC_OFS_CMD, 32'h1);
		check({acq_running, mem_region}, 32'h10001);
		apb(1, `MSAC_OFS_CMD, 32'h1);
		tick(1);
		check(acq_running, 32'h0);
		// Single sweeps: drain with a stalling host, then resume
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_SWP_PRE, 32'h1);
		apb(1, `MSAC_OFS_RANGE, 32'h1);
		apb(1, `MSAC_OFS_DELAY, 32'h0);
		apb(1, `MSAC_OFS_CTRL, 32'h39);
		for (int i = 0; i < 2; i++) begin
			start();
			exp.push_back(32'h0);
			tick(100);
		end
		cmp_q();
		check(acq_running, 32'h1);
		// Wrap, soft start, bin width 2: begin pulse, then bits above range masked
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_RANGE, 32'h2);
		apb(1, `MSAC_OFS_BINW, 32'h1);
		apb(1, `MSAC_OFS_SYNC1, 32'h1);
		apb(1, `MSAC_OFS_CTRL, 32'h7);
		tick(3);
		check(sync_out1, 1'b1);
		tick(1);
		check(sync_out1, 1'b0);
		tick(176);
		exp.push_back(32'h1);
		stop();
		tick(2);
		cmp_q();
		// Overflow sync follows the stage with one cycle lag
		apb(1, `MSAC_OFS_CTRL, 32'h0);
		apb(1, `MSAC_OFS_SYNC0, 32'h3);
		tick(2);
		o = ovf1;
		repeat (40) begin
			stop_event <= lfsr[3];
			@(posedge clk);
			check(sync_out0, o);
			o = ovf1;
		end
		stop_event <= 1'b0;
		summarize();
	end
endmodule // msac_top_test
